//--- lane_config_and_detect_regs_test.sv
// self-checking bench of the lane config and detect register slice
`timescale 1ns/10ps
`default_nettype none
module lane_config_and_detect_regs_test;
	localparam int PCYC = 20;
	localparam int PTRIES = 3;
	logic clk, rst, wr, rd, srst, ovr, ren, flt, found, probe, term, prot;
	logic [7:0] addr, wdata, rdata, det_n, eq, q;
	logic [1:0] smode;
	logic [2:0] ratio;
	int error_cnt, total_checks, pulses;
	logic [7:0] ra [9] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h20};
	logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00, 8'h2F, 8'hAD, 8'h00};

	lcdr_regs #(.PROBE_CYC(PCYC), .PROBE_TRIES(PTRIES)) u_dut (.I_CLK(clk), .I_RST(rst),
		.I_REG_SOFT_RST(srst), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
		.I_REG_RD(rd), .O_REG_RDATA(rdata), .I_FAR_RECEIVER_PROBE_OVERRIDE(ovr), .I_REG_ENABLE(ren),
		.I_SIG_DETECT_N(det_n), .I_SPARE_STRAP_FLOAT(flt), .I_PROBE_STRAP_MODE(smode),
		.I_FAR_RX_FOUND(found), .O_PROBE(probe), .O_TERM_50OHM(term),
		.O_EQUALIZER_BOOST(eq), .O_SHORT_PROT(prot), .O_SWING_RATIO(ratio));

	lcdr_host u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
		.o_wdata(wdata), .o_rd(rd), .o_soft_rst(srst));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(negedge clk)
		if (probe === 1'b1)
			pulses = pulses + 1;

	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, q);
		chk($sformatf("reg %h", a), e, q);
	endtask

	task automatic outs(input logic [7:0] e, input logic p, input logic [2:0] r);
		chk("eq", e, eq);
		chk("prot", {7'h0, p}, {7'h0, prot});
		chk("ratio", {5'h0, r}, {5'h0, ratio});
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end

	initial
	begin
		rst = 1'b1;
		{ovr, ren, flt, found} = 4'h0;
		det_n = 8'hFF;
		smode = 2'h0;
		pulses = 0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 9; i++)
			rchk(ra[i], rv[i]);
		outs(8'h2F, 1'b1, 3'h5);
		chk("term", 8'h00, {7'h0, term});
		u_host.wr(8'h0F, 8'h11);
		u_host.wr_swing(1'b0, 3'h6);
		u_host.wr(8'h0E, 8'hFF);
		u_host.wr(8'h0A, 8'h55);
		u_host.keep_spare();
		u_host.wr(8'h30, 8'h12);
		rchk(8'h0F, 8'h11);
		rchk(8'h10, 8'h2E);
		rchk(8'h0E, 8'h0C);
		rchk(8'h0A, 8'h00);
		rchk(8'h0B, 8'h70);
		rchk(8'h30, 8'h00);
		outs(8'h2F, 1'b1, 3'h5);
		ren = 1'b1;
		repeat (2) @(negedge clk);
		outs(8'h11, 1'b0, 3'h6);
		u_host.soft_rst();
		rchk(8'h10, 8'hAD);
		outs(8'h2F, 1'b1, 3'h5);
		det_n = 8'h5A;
		repeat (4) @(negedge clk);
		rchk(8'h0A, 8'h00);
		flt = 1'b1;
		repeat (4) @(negedge clk);
		rchk(8'h0A, 8'h5A);
		smode = 2'h3;
		repeat (5) @(negedge clk);
		chk("term strap", 8'h01, {7'h0, term});
		ovr = 1'b1;
		repeat (3) @(negedge clk);
		chk("term reg off", 8'h00, {7'h0, term});
		u_host.wr(8'h0E, 8'h0C);
		repeat (2) @(negedge clk);
		chk("term reg on", 8'h01, {7'h0, term});
		u_host.wr(8'h0E, 8'h04);
		pulses = 0;
		repeat (10 * PCYC) @(negedge clk);
		chk("tries", PTRIES[7:0], pulses[7:0]);
		chk("term lim", 8'h00, {7'h0, term});
		u_host.wr(8'h0E, 8'h08);
		pulses = 0;
		repeat (10 * PCYC) @(negedge clk);
		chk("endless", 8'h01, {7'h0, pulses >= 8});
		chk("term hiz", 8'h00, {7'h0, term});
		found = 1'b1;
		for (int i = 0; i < 10 && term !== 1'b1; i++)
			@(negedge clk);
		chk("term found", 8'h01, {7'h0, term});
		wrap_up();
	end
endmodule
`default_nettype wire

//--- lcdr_cfg.svh
// offsets, field positions, reset values and timing counts of the lane config block
`ifndef LCDR_CFG_SVH
`define LCDR_CFG_SVH

`define LCDR_ADDR_SPARE_A 8'h09
`define LCDR_ADDR_MONITOR 8'h0A
`define LCDR_ADDR_SPARE_B 8'h0B
`define LCDR_ADDR_SPARE_C 8'h0C
`define LCDR_ADDR_SPARE_D 8'h0D
`define LCDR_ADDR_TERM 8'h0E
`define LCDR_ADDR_EQ 8'h0F
`define LCDR_ADDR_SWING 8'h10

`define LCDR_RST_SPARE_A 8'h00
`define LCDR_RST_MONITOR 8'h00
`define LCDR_RST_SPARE_B 8'h70
`define LCDR_RST_SPARE_C 8'h00
`define LCDR_RST_SPARE_D 8'h00
`define LCDR_RST_PROBE 2'h0
`define LCDR_RST_EQ 8'h2F
`define LCDR_RST_SWING 8'hAD
`define LCDR_UNMAPPED_DATA 8'h00

`define LCDR_PROBE_LSB 2
`define LCDR_PROBE_MSB 3
`define LCDR_SCP_BIT 7
`define LCDR_RATIO_MSB 2

`define LCDR_CLK_KHZ 125000
`define LCDR_PROBE_INTERVAL_MS 12
`define LCDR_PROBE_WINDOW_MS 600
`define LCDR_PROBE_CYC (`LCDR_PROBE_INTERVAL_MS * `LCDR_CLK_KHZ)
`define LCDR_PROBE_TRIES (`LCDR_PROBE_WINDOW_MS / `LCDR_PROBE_INTERVAL_MS)

`endif

//--- lcdr_host.sv
// management host model driving the register port of the lane config block
`timescale 1ns/10ps
`default_nettype none
module lcdr_host (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd,
	output logic o_soft_rst
);
	initial
	begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
		o_soft_rst = 1'b0;
	end

	// single byte write, data inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask

	// single byte read, data sampled once settled
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge i_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk);
		o_rd = 1'b0;
		@(negedge i_clk);
		q = i_rdata;
	endtask

	// swing write keeps the reserved pattern
	task automatic wr_swing(input logic prot, input logic [2:0] ratio);
		wr(8'h10, {prot, 4'h5, ratio});
	endtask

	// spare register kept at its required pattern
	task automatic keep_spare;
		wr(8'h0B, 8'h70);
	endtask

	task automatic soft_rst;
		@(negedge i_clk);
		o_soft_rst = 1'b1;
		@(negedge i_clk);
		o_soft_rst = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- lcdr_pkg.sv
// types of the lane config block
package lcdr_pkg;
	typedef enum logic [1:0] {
		LCDR_PROBE_OFF = 2'h0,
		LCDR_PROBE_LIMITED = 2'h1,
		LCDR_PROBE_ENDLESS = 2'h2,
		LCDR_PROBE_ON = 2'h3
	} lcdr_probe_mode_t;

	typedef enum logic [3:0] {
		LCDR_ST_HIZ = 4'h1,
		LCDR_ST_PROBE = 4'h2,
		LCDR_ST_TERM = 4'h4,
		LCDR_ST_STOP = 4'h8
	} lcdr_probe_state_t;
endpackage

//--- lcdr_probe_timer.sv
// far receiver probe timer and termination state for lane b0
`timescale 1ns/10ps
`default_nettype none
module lcdr_probe_timer #(
	parameter int INTERVAL_CYC = 1500000,
	parameter int MAX_TRIES = 50
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire lcdr_pkg::lcdr_probe_mode_t i_mode,
	input wire logic i_found,
	output logic o_probe,
	output logic o_term
);
	import lcdr_pkg::*;

	localparam int CW = $clog2(INTERVAL_CYC);
	localparam int TW = $clog2(MAX_TRIES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(INTERVAL_CYC - 1);
	localparam logic [TW-1:0] TRY_MAX = TW'(MAX_TRIES);

	lcdr_probe_state_t state_r;
	lcdr_probe_mode_t mode_r;
	logic [CW-1:0] cnt_r;
	logic [TW-1:0] tries_r;
	logic mode_chg;
	logic fire;
	logic give_up;

	assign mode_chg = (i_mode != mode_r);
	assign fire = (state_r == LCDR_ST_PROBE) && (cnt_r == CNT_LAST);
	assign give_up = fire && (i_mode == LCDR_PROBE_LIMITED) && (tries_r == TRY_MAX);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			mode_r <= LCDR_PROBE_OFF;
		else
			mode_r <= i_mode;
	end

	// termination state per code
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			state_r <= LCDR_ST_HIZ;
		else if (mode_chg)
		begin
			unique case (i_mode)
				LCDR_PROBE_OFF: state_r <= LCDR_ST_HIZ;
				LCDR_PROBE_ON: state_r <= LCDR_ST_TERM;
				LCDR_PROBE_LIMITED, LCDR_PROBE_ENDLESS: state_r <= LCDR_ST_PROBE;
			endcase
		end
		else
		begin
			unique case (state_r)
				LCDR_ST_PROBE:
				begin
					if (i_found)
						state_r <= LCDR_ST_TERM;
					else if (give_up)
						state_r <= LCDR_ST_STOP;
				end
				LCDR_ST_HIZ, LCDR_ST_TERM, LCDR_ST_STOP: state_r <= state_r;
				default: state_r <= LCDR_ST_HIZ;
			endcase
		end
	end

	// interval counter, restarts on code change
	always_ff @(posedge i_clk)
	begin
		if (i_rst || mode_chg || state_r != LCDR_ST_PROBE || fire)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst || mode_chg)
			tries_r <= '0;
		else if (fire && !give_up && tries_r != TRY_MAX)
			tries_r <= tries_r + 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_probe <= 1'b0;
		else
			o_probe <= fire && !give_up && !i_found && !mode_chg;
	end

	assign o_term = state_r[2];

	a_forced_term: assert property (@(posedge i_clk) disable iff (i_rst) (i_mode == LCDR_PROBE_ON) [*2] |-> o_term)
		else $error("code 11 did not terminate");
	a_hiz_hold: assert property (@(posedge i_clk) disable iff (i_rst) (i_mode == LCDR_PROBE_OFF) [*2] |-> !o_term)
		else $error("code 00 did not keep hi-z");
	sequence s_probe_hit;
		(state_r == LCDR_ST_PROBE) && i_found && !mode_chg;
	endsequence
	a_found_term: assert property (@(posedge i_clk) disable iff (i_rst) s_probe_hit |=> o_term)
		else $error("detection did not terminate");
	a_tries_bound: assert property (@(posedge i_clk) disable iff (i_rst) tries_r <= TRY_MAX)
		else $error("probe attempts exceeded limit");
	a_restart_cnt: assert property (@(posedge i_clk) disable iff (i_rst) mode_chg |=> cnt_r == '0)
		else $error("counter did not restart on code change");
endmodule
`default_nettype wire

//--- lcdr_regs.sv
// lane configuration and signal detect register slice
`timescale 1ns/10ps
`default_nettype none
`include "lcdr_cfg.svh"
module lcdr_regs #(
	parameter int PROBE_CYC = `LCDR_PROBE_CYC,
	parameter int PROBE_TRIES = `LCDR_PROBE_TRIES
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_REG_SOFT_RST,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic I_REG_WR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic I_REG_RD,
	output logic [7:0] O_REG_RDATA,
	input wire logic I_FAR_RECEIVER_PROBE_OVERRIDE,
	input wire logic I_REG_ENABLE,
	input wire logic [7:0] I_SIG_DETECT_N,
	input wire logic I_SPARE_STRAP_FLOAT,
	input wire logic [1:0] I_PROBE_STRAP_MODE,
	input wire logic I_FAR_RX_FOUND,
	output logic O_PROBE,
	output logic O_TERM_50OHM,
	output logic [7:0] O_EQUALIZER_BOOST,
	output logic O_SHORT_PROT,
	output logic [2:0] O_SWING_RATIO
);
	import lcdr_pkg::*;

	logic [7:0] sd_meta_r;
	logic [7:0] sd_sync_r;
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic [7:0] monitor_r;
	logic [7:0] spare_a_r;
	logic [7:0] spare_b_r;
	logic [7:0] spare_c_r;
	logic [7:0] spare_d_r;
	logic [1:0] probe_code_r;
	logic [7:0] eq_r;
	logic [7:0] swing_r;
	logic reg_init;
	lcdr_probe_mode_t probe_mode;
	logic [7:0] rdata_nxt;

	function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target, input logic wr);
		wr_hit = wr && (addr == target);
	endfunction

	assign reg_init = I_RST || I_REG_SOFT_RST;

	// two-stage synchronisers for pins
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			sd_meta_r <= 8'hFF;
			sd_sync_r <= 8'hFF;
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
		end
		else
		begin
			sd_meta_r <= I_SIG_DETECT_N;
			sd_sync_r <= sd_meta_r;
			pin_meta_r <= {I_FAR_RX_FOUND, I_SPARE_STRAP_FLOAT, I_PROBE_STRAP_MODE};
			pin_sync_r <= pin_meta_r;
		end
	end

	// signal detect monitor
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			monitor_r <= `LCDR_RST_MONITOR;
		else if (pin_sync_r[2])
			monitor_r <= sd_sync_r;
		else
			monitor_r <= `LCDR_RST_MONITOR;
	end

	// spare registers, plain storage
	always_ff @(posedge I_CLK)
	begin
		if (reg_init)
		begin
			spare_a_r <= `LCDR_RST_SPARE_A;
			spare_b_r <= `LCDR_RST_SPARE_B;
			spare_c_r <= `LCDR_RST_SPARE_C;
			spare_d_r <= `LCDR_RST_SPARE_D;
		end
		else
		begin
			if (wr_hit(I_REG_ADDR, `LCDR_ADDR_SPARE_A, I_REG_WR))
				spare_a_r <= I_REG_WDATA;
			if (wr_hit(I_REG_ADDR, `LCDR_ADDR_SPARE_B, I_REG_WR))
				spare_b_r <= I_REG_WDATA;
			if (wr_hit(I_REG_ADDR, `LCDR_ADDR_SPARE_C, I_REG_WR))
				spare_c_r <= I_REG_WDATA;
			if (wr_hit(I_REG_ADDR, `LCDR_ADDR_SPARE_D, I_REG_WR))
				spare_d_r <= I_REG_WDATA;
		end
	end

	// probe code field
	always_ff @(posedge I_CLK)
	begin
		if (reg_init)
			probe_code_r <= `LCDR_RST_PROBE;
		else if (wr_hit(I_REG_ADDR, `LCDR_ADDR_TERM, I_REG_WR))
			probe_code_r <= I_REG_WDATA[`LCDR_PROBE_MSB:`LCDR_PROBE_LSB];
	end

	// equalizer and swing registers
	always_ff @(posedge I_CLK)
	begin
		if (reg_init)
		begin
			eq_r <= `LCDR_RST_EQ;
			swing_r <= `LCDR_RST_SWING;
		end
		else
		begin
			if (wr_hit(I_REG_ADDR, `LCDR_ADDR_EQ, I_REG_WR))
				eq_r <= I_REG_WDATA;
			if (wr_hit(I_REG_ADDR, `LCDR_ADDR_SWING, I_REG_WR))
				swing_r <= I_REG_WDATA;
		end
	end

	// probe mode source
	assign probe_mode = lcdr_probe_mode_t'(I_FAR_RECEIVER_PROBE_OVERRIDE ? probe_code_r : pin_sync_r[1:0]);

	lcdr_probe_timer #(
		.INTERVAL_CYC(PROBE_CYC),
		.MAX_TRIES(PROBE_TRIES)
	) u_probe (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_mode(probe_mode),
		.i_found(pin_sync_r[3]),
		.o_probe(O_PROBE),
		.o_term(O_TERM_50OHM)
	);

	// applied analog settings
	always_ff @(posedge I_CLK)
	begin
		if (I_RST || !I_REG_ENABLE)
		begin
			O_EQUALIZER_BOOST <= `LCDR_RST_EQ;
			O_SHORT_PROT <= 1'(`LCDR_RST_SWING >> `LCDR_SCP_BIT);
			O_SWING_RATIO <= 3'(`LCDR_RST_SWING);
		end
		else
		begin
			O_EQUALIZER_BOOST <= eq_r;
			O_SHORT_PROT <= swing_r[`LCDR_SCP_BIT];
			O_SWING_RATIO <= swing_r[`LCDR_RATIO_MSB:0];
		end
	end

	// read mux
	always_comb
	begin
		unique case (I_REG_ADDR)
			`LCDR_ADDR_SPARE_A: rdata_nxt = spare_a_r;
			`LCDR_ADDR_MONITOR: rdata_nxt = monitor_r;
			`LCDR_ADDR_SPARE_B: rdata_nxt = spare_b_r;
			`LCDR_ADDR_SPARE_C: rdata_nxt = spare_c_r;
			`LCDR_ADDR_SPARE_D: rdata_nxt = spare_d_r;
			`LCDR_ADDR_TERM: rdata_nxt = {4'h0, probe_code_r, 2'h0};
			`LCDR_ADDR_EQ: rdata_nxt = eq_r;
			`LCDR_ADDR_SWING: rdata_nxt = swing_r;
			default: rdata_nxt = `LCDR_UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			O_REG_RDATA <= 8'h00;
		else if (I_REG_RD)
			O_REG_RDATA <= rdata_nxt;
	end

	a_monitor_live: assert property (@(posedge I_CLK) disable iff (I_RST)
		pin_sync_r[2] |=> monitor_r == $past(sd_sync_r))
		else $error("monitor does not follow detect");
	a_monitor_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
		!pin_sync_r[2] |=> monitor_r == `LCDR_RST_MONITOR)
		else $error("monitor valid while strap driven");
	a_monitor_read: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_REG_RD && I_REG_ADDR == `LCDR_ADDR_MONITOR |=> O_REG_RDATA == $past(monitor_r))
		else $error("monitor read mismatch");
	a_reset_vals: assert property (@(posedge I_CLK)
		I_RST |=> eq_r == `LCDR_RST_EQ && swing_r == `LCDR_RST_SWING && probe_code_r == 2'h0)
		else $error("reset values wrong");
	a_swing_write: assert property (@(posedge I_CLK) disable iff (reg_init)
		wr_hit(I_REG_ADDR, `LCDR_ADDR_SWING, I_REG_WR) |=> swing_r == $past(I_REG_WDATA))
		else $error("swing write lost");
	a_strap_rules: assert property (@(posedge I_CLK) disable iff (I_RST)
		!I_FAR_RECEIVER_PROBE_OVERRIDE |-> probe_mode == pin_sync_r[1:0])
		else $error("strap ignored without override");
	a_pin_defaults: assert property (@(posedge I_CLK) disable iff (I_RST)
		!I_REG_ENABLE |=> O_EQUALIZER_BOOST == `LCDR_RST_EQ && O_SWING_RATIO == 3'h5)
		else $error("settings applied without enable");
	a_scp_apply: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_REG_ENABLE |=> O_SHORT_PROT == $past(swing_r[7]) && O_SWING_RATIO == $past(swing_r[2:0]))
		else $error("swing settings not applied");
endmodule
`default_nettype wire
